// ===== verilog/drmsb_pkg.sv
/*
  Constants, parameter addresses and decode function of the drive monitor status bank.
  Assumes a fieldbus front end that delivers one parameter access per request.
*/
package drmsb_pkg;

  // ---------------------------------------------------------------
  // Modbus parameter addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] MB_USER1 = 16'h013e;
  localparam logic [15:0] MB_USER2 = 16'h0140;
  localparam logic [15:0] MB_USER3 = 16'h0142;
  localparam logic [15:0] MB_STOP = 16'h1c0a;
  localparam logic [15:0] MB_LIVE = 16'h1c0e;
  localparam logic [15:0] MB_LATCH = 16'h1c10;
  localparam logic [15:0] MB_UDC = 16'h1c1e;
  localparam logic [15:0] MB_TEMP = 16'h1c20;

  // ---------------------------------------------------------------
  // CANopen index and subindex, joined as index:sub
  // ---------------------------------------------------------------
  localparam logic [23:0] CO_USER1 = 24'h30011f;
  localparam logic [23:0] CO_USER2 = 24'h300120;
  localparam logic [23:0] CO_USER3 = 24'h300121;
  localparam logic [23:0] CO_STOP = 24'h603f00;
  localparam logic [23:0] CO_LIVE = 24'h301c07;
  localparam logic [23:0] CO_LATCH = 24'h301c08;
  localparam logic [23:0] CO_UDC = 24'h301c0f;
  localparam logic [23:0] CO_TEMP = 24'h301c10;

  // ---------------------------------------------------------------
  // Monitoring flag positions
  // ---------------------------------------------------------------
  localparam int BIT_GENERAL = 0;
  localparam int BIT_LIMIT_SW = 1;
  localparam int BIT_RANGE = 2;
  localparam int BIT_QSTOP = 3;
  localparam int BIT_STO_ZERO = 4;
  localparam int BIT_RS485 = 6;
  localparam int BIT_CAN = 7;
  localparam int BIT_ETH = 8;
  localparam int BIT_REF_FREQ = 9;
  localparam int BIT_OPMODE = 10;
  localparam int BIT_FIELDBUS = 12;
  localparam int BIT_DC_UNDER = 14;
  localparam int BIT_DC_OVER = 15;
  localparam int BIT_MAINS = 16;
  localparam int BIT_MOTOR_CONN = 17;
  localparam int BIT_MOTOR_OC = 18;
  localparam int BIT_ENCODER = 19;
  localparam int BIT_24V_UNDER = 20;
  localparam int BIT_OVERTEMP = 21;
  localparam int BIT_POS_DEV = 22;
  localparam int BIT_MAX_VEL = 23;
  localparam int BIT_STO_DIFF = 24;
  localparam int BIT_NVM = 29;
  localparam int BIT_BOOT = 30;
  localparam int BIT_SYSTEM = 31;

  // Bits 5, 11, 13 and 25 to 28 carry nothing
  localparam logic [31:0] FLAG_RSV_MASK = 32'h1e00_2820;
  localparam logic [31:0] FLAG_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Reset values and stop classes
  // ---------------------------------------------------------------
  localparam logic [31:0] USER_RESET = 32'h0000_0000;
  localparam logic [15:0] STOP_RESET = 16'h0000;
  localparam logic [2:0] STOP_CLASS_MIN = 3'h1;
  localparam logic [2:0] STOP_CLASS_MAX = 3'h4;
  localparam int USER_WORDS = 3;

  // One-hot parameter select
  typedef enum logic [8:0] {
    SEL_NONE = 9'h001,
    SEL_USER1 = 9'h002,
    SEL_USER2 = 9'h004,
    SEL_USER3 = 9'h008,
    SEL_STOP = 9'h010,
    SEL_LATCH = 9'h020,
    SEL_LIVE = 9'h040,
    SEL_UDC = 9'h080,
    SEL_TEMP = 9'h100
  } drmsb_sel_t;

  function automatic drmsb_sel_t drmsb_decode(
    input logic space,
    input logic [15:0] mb,
    input logic [23:0] co
  );
    drmsb_sel_t s;
    s = SEL_NONE;
    if (!space) begin
      case (mb)
        MB_USER1: s = SEL_USER1;
        MB_USER2: s = SEL_USER2;
        MB_USER3: s = SEL_USER3;
        MB_STOP: s = SEL_STOP;
        MB_LIVE: s = SEL_LIVE;
        MB_LATCH: s = SEL_LATCH;
        MB_UDC: s = SEL_UDC;
        MB_TEMP: s = SEL_TEMP;
        default: s = SEL_NONE;
      endcase
    end else begin
      case (co)
        CO_USER1: s = SEL_USER1;
        CO_USER2: s = SEL_USER2;
        CO_USER3: s = SEL_USER3;
        CO_STOP: s = SEL_STOP;
        CO_LIVE: s = SEL_LIVE;
        CO_LATCH: s = SEL_LATCH;
        CO_UDC: s = SEL_UDC;
        CO_TEMP: s = SEL_TEMP;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

endpackage

// ===== verilog/drmsb_flag_latch.sv
/*
  Live and sticky monitoring flag registers.
  Assumes condition inputs are synchronous levels and clear is a one-cycle pulse.
*/
`timescale 1ns/1ps
module drmsb_flag_latch #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RSV_MASK = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Conditions and fault reset
  input wire logic [WIDTH-1:0] live_in,
  input wire logic clear,
  // Flag words
  output logic [WIDTH-1:0] live_reg,
  output logic [WIDTH-1:0] latched_reg
);
  import drmsb_pkg::*;

  logic [WIDTH-1:0] live_next;
  logic [WIDTH-1:0] latched_next;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("Flag width must be at least one");
    end
  endgenerate

  // Reserved positions never show a condition
  assign live_next = live_in & ~RSV_MASK;  // [RULE8] [RULE17] [RULE15]
  // New condition outranks a fault reset in the same cycle
  assign latched_next = (latched_reg & {WIDTH{~clear}}) | live_next;  // [RULE16] [RULE2]

  always_ff @(posedge clk) begin
    if (!rstn) begin
      live_reg <= '0;
      latched_reg <= '0;
    end else begin
      live_reg <= live_next;
      latched_reg <= latched_next;
    end
  end

endmodule

// ===== verilog/drmsb_bank.sv
/*
  Drive monitor status bank: fieldbus-readable monitoring, stop code,
  measurements and persistent user words.
  Assumes a fieldbus front end issuing single-cycle requests, a nonvolatile
  store that restores user words after power-up, and synchronous inputs.
*/
`timescale 1ns/1ps

// Operation
// [RULE1] A read-only 32-bit word holds the saved state of every monitored condition.
// [RULE2] Each saved bit reads 1 once its condition has been active and 0 otherwise.
// [RULE3] Bits 0 to 4 flag general error, limit switch, range, quick stop and safe torque off at 0.
// [RULE4] Bits 6 to 10 flag RS485, CAN, Ethernet, reference frequency and mode; bit 12 fieldbus.
// [RULE5] Bits 14 to 19 flag DC bus under and over voltage, mains, motor wiring, current, encoder.
// [RULE6] Bits 20 to 24 flag 24 V low, overtemperature, position, velocity, safe input mismatch.
// [RULE7] Bits 29 to 31 flag nonvolatile memory, booting and system faults.
// [RULE8] Bits 5, 11, 13, 25, 27 and 28 are reserved and carry nothing.
// [RULE9] The code of the latest stopping error, class 1 to 4, is recorded.
// [RULE10] The stop code is a read-only 16-bit word starting at 0.
// [RULE11] DC bus voltage is read-only, unsigned 16 bits, in tenths of a volt.
// [RULE12] Power stage temperature is read-only, signed 16 bits, in degrees Celsius.
// [RULE13] Three 32-bit user words are read-write, persistent and start at 0.
// [RULE14] Every parameter sits at a fixed CANopen index:subindex and a fixed Modbus address.
// [RULE15] A live word with the same bit layout shows only currently active conditions.
// [RULE16] A saved bit sets when its condition is active and stays until a fault reset.
// [RULE17] Bit 26 is reserved and reads 0.
module drmsb_bank #(
  parameter int FLAG_WIDTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Parameter access
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_space,
  input wire logic [15:0] req_mb_addr,
  input wire logic [15:0] req_co_index,
  input wire logic [7:0] req_co_sub,
  input wire logic [31:0] req_wdata,
  output logic resp_valid,
  output logic resp_error,
  output logic [31:0] resp_rdata,
  // Monitoring conditions
  input wire logic [31:0] live_conditions,
  input wire logic fault_reset,
  // Stopping errors
  input wire logic stop_event,
  input wire logic [2:0] stop_class,
  input wire logic [15:0] stop_code,
  // Measurements
  input wire logic [15:0] dc_bus_voltage_in,
  input wire logic [15:0] power_stage_temperature_in,
  // Nonvolatile store
  input wire logic nv_load_valid,
  input wire logic [1:0] nv_load_slot,
  input wire logic [31:0] nv_load_data,
  output logic nv_save_valid,
  output logic [1:0] nv_save_slot,
  output logic [31:0] nv_save_data
);
  import drmsb_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0] live_monitor_flags;
  logic [31:0] latched_monitor_flags;
  logic [15:0] stop_error_code_reg;
  logic [15:0] stop_error_code_next;
  logic [15:0] dc_bus_voltage_reg;
  logic signed [15:0] power_stage_temperature_reg;
  logic [31:0] user_reg [USER_WORDS];
  logic [31:0] user_next [USER_WORDS];
  logic resp_valid_next;
  logic resp_error_next;
  logic [31:0] resp_rdata_next;
  logic nv_save_valid_next;

  drmsb_sel_t sel_w;
  wire [23:0] co_key_w = {req_co_index, req_co_sub};
  wire [1:0] user_slot_w;
  wire is_user_w;
  wire is_ro_w;
  wire is_none_w;
  wire user_wr_w;
  wire stop_take_w;
  wire [31:0] rd_mux_w;

  generate
    if (FLAG_WIDTH != 32) begin : g_bad_flags
      $error("Monitoring word layout needs exactly 32 bits");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Monitoring flags
  // ---------------------------------------------------------------
  // Conditions arrive already in position order
  drmsb_flag_latch #(
    .WIDTH(FLAG_WIDTH),
    .RSV_MASK(FLAG_RSV_MASK)
  ) u_flags (
    .clk(clk),
    .rstn(rstn),
    .live_in(live_conditions),  // [RULE3] [RULE4] [RULE5] [RULE6] [RULE7]
    .clear(fault_reset),
    .live_reg(live_monitor_flags),
    .latched_reg(latched_monitor_flags)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  assign sel_w = drmsb_decode(req_space, req_mb_addr, co_key_w);  // [RULE14]
  assign is_none_w = (sel_w == SEL_NONE);
  assign is_user_w = (sel_w == SEL_USER1) || (sel_w == SEL_USER2)
                     || (sel_w == SEL_USER3);
  assign is_ro_w = !is_user_w && !is_none_w;  // [RULE1] [RULE10]
  assign user_slot_w = (sel_w == SEL_USER3) ? 2'h2 :
                       (sel_w == SEL_USER2) ? 2'h1 : 2'h0;
  assign user_wr_w = req_valid && req_write && is_user_w;  // [RULE13]

  // ---------------------------------------------------------------
  // Read data select
  // ---------------------------------------------------------------
  // Narrow words sit in the low half, upper half reads zero
  assign rd_mux_w =
      ({32{sel_w == SEL_USER1}} & user_reg[0])
    | ({32{sel_w == SEL_USER2}} & user_reg[1])
    | ({32{sel_w == SEL_USER3}} & user_reg[2])
    | ({32{sel_w == SEL_STOP}} & {16'h0000, stop_error_code_reg})
    | ({32{sel_w == SEL_LATCH}} & latched_monitor_flags)
    | ({32{sel_w == SEL_LIVE}} & live_monitor_flags)
    | ({32{sel_w == SEL_UDC}} & {16'h0000, dc_bus_voltage_reg})  // [RULE11]
    | ({32{sel_w == SEL_TEMP}} & {16'h0000, power_stage_temperature_reg});  // [RULE12]

  // Writes to read-only or unmapped words answer with an error
  assign resp_valid_next = req_valid;
  assign resp_error_next = req_valid && (is_none_w || (req_write && is_ro_w));
  assign resp_rdata_next = (req_valid && !req_write) ? rd_mux_w : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Stop code capture
  // ---------------------------------------------------------------
  // Class 0 entries are warnings and leave the stop code alone
  assign stop_take_w = stop_event && (stop_class >= STOP_CLASS_MIN)
                       && (stop_class <= STOP_CLASS_MAX);
  assign stop_error_code_next = stop_take_w ? stop_code : stop_error_code_reg;  // [RULE9]

  // ---------------------------------------------------------------
  // User words
  // ---------------------------------------------------------------
  // A fieldbus write outranks a restore aimed at the same slot
  always_comb begin
    for (int i = 0; i < USER_WORDS; i++) begin
      user_next[i] = user_reg[i];
      if (nv_load_valid && (nv_load_slot == 2'(i))) begin
        user_next[i] = nv_load_data;
      end
      if (user_wr_w && (user_slot_w == 2'(i))) begin
        user_next[i] = req_wdata;  // [RULE13]
      end
    end
  end

  // Every accepted write is mirrored to the store so it survives power loss
  // Store must keep up with one write per cycle; there is no backpressure
  assign nv_save_valid_next = user_wr_w;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Measurements are plain one-cycle copies, no filtering or range check
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < USER_WORDS; i++) begin
        user_reg[i] <= USER_RESET;
      end
    end else begin
      for (int i = 0; i < USER_WORDS; i++) begin
        user_reg[i] <= user_next[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stop_error_code_reg <= STOP_RESET;  // [RULE10]
      dc_bus_voltage_reg <= 16'h0000;
      power_stage_temperature_reg <= 16'sh0000;
    end else begin
      stop_error_code_reg <= stop_error_code_next;
      dc_bus_voltage_reg <= dc_bus_voltage_in;  // [RULE11]
      power_stage_temperature_reg <= power_stage_temperature_in;  // [RULE12]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_rdata <= 32'h0000_0000;
    end else begin
      resp_valid <= resp_valid_next;
      resp_error <= resp_error_next;
      resp_rdata <= resp_rdata_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      nv_save_valid <= 1'b0;
      nv_save_slot <= 2'h0;
      nv_save_data <= 32'h0000_0000;
    end else begin
      nv_save_valid <= nv_save_valid_next;
      nv_save_slot <= user_slot_w;
      nv_save_data <= req_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_answer_next_cycle: assert property ( // [RULE14]
    req_valid |=> resp_valid
  ) else $error("Request not answered in the next cycle");

  chk_answer_without_req: assert property ( // [RULE14]
    !req_valid |=> !resp_valid && !resp_error
  ) else $error("Answer without a request");

  chk_latched_readback: assert property ( // [RULE1]
    req_valid && !req_write && req_space == 1'b0 && req_mb_addr == MB_LATCH
    |=> resp_rdata == $past(latched_monitor_flags) && !resp_error
  ) else $error("Saved flag word read back wrong");

  chk_canopen_user: assert property ( // [RULE14]
    req_valid && !req_write && req_space && co_key_w == CO_USER1
    |=> resp_rdata == $past(user_reg[0])
  ) else $error("CANopen access to first user word wrong");

  chk_flag_sets: assert property ( // [RULE2]
    live_conditions != 32'h0000_0000
    |=> (latched_monitor_flags & $past(live_conditions & ~FLAG_RSV_MASK))
        == $past(live_conditions & ~FLAG_RSV_MASK)
  ) else $error("Active condition did not set its saved bit");

  chk_flag_sticky: assert property ( // [RULE16]
    !fault_reset ##1 1'b1
    |-> (latched_monitor_flags & $past(latched_monitor_flags))
        == $past(latched_monitor_flags)
  ) else $error("Saved bit dropped without a fault reset");

  chk_flag_cleared: assert property ( // [RULE16]
    fault_reset && live_conditions == 32'h0000_0000
    |=> latched_monitor_flags == 32'h0000_0000
  ) else $error("Fault reset did not clear saved bits");

  chk_reserved_zero: assert property ( // [RULE8]
    (latched_monitor_flags & FLAG_RSV_MASK) == 32'h0000_0000
    && !latched_monitor_flags[26] && !live_monitor_flags[26]  // [RULE17]
  ) else $error("Reserved flag bit set");

  chk_flag_positions: assert property ( // [RULE3]
    live_conditions[BIT_STO_ZERO] && live_conditions[BIT_ETH]
    && live_conditions[BIT_ENCODER] && live_conditions[BIT_STO_DIFF]
    && live_conditions[BIT_SYSTEM]
    |=> latched_monitor_flags[4] && latched_monitor_flags[8]  // [RULE4]
        && latched_monitor_flags[19] && latched_monitor_flags[24]  // [RULE5] [RULE6]
        && latched_monitor_flags[31]  // [RULE7]
  ) else $error("Flag landed at the wrong position");

  chk_live_mirror: assert property ( // [RULE15]
    1'b1 |=> live_monitor_flags == ($past(live_conditions) & ~FLAG_RSV_MASK)
  ) else $error("Live word does not follow conditions");

  chk_stop_capture: assert property ( // [RULE9]
    stop_event && stop_class inside {[3'h1:3'h4]}
    |=> stop_error_code_reg == $past(stop_code)
  ) else $error("Stopping error code not recorded");

  chk_stop_ignored: assert property ( // [RULE9]
    !stop_event || stop_class == 3'h0 || stop_class > 3'h4
    |=> $stable(stop_error_code_reg)
  ) else $error("Stop code changed without a stopping error");

  chk_stop_reset: assert property ( // [RULE10]
    $rose(rstn) |-> stop_error_code_reg == 16'h0000
  ) else $error("Stop code not zero after reset");

  chk_ro_refused: assert property ( // [RULE10]
    req_valid && req_write && is_ro_w
    |=> resp_error ##0 $stable(stop_error_code_reg) || $past(stop_take_w)
  ) else $error("Write to read-only word not refused");

  chk_user_write: assert property ( // [RULE13]
    req_valid && req_write && sel_w == SEL_USER2
    |=> user_reg[1] == $past(req_wdata) && nv_save_valid && nv_save_slot == 2'h1
  ) else $error("User word write not stored and saved");

  // Gated on rstn so the cycle that leaves reset is not held against a stale input
  chk_measure_track: assert property ( // [RULE11]
    rstn |=> dc_bus_voltage_reg == $past(dc_bus_voltage_in)
             && power_stage_temperature_reg == $past(power_stage_temperature_in)  // [RULE12]
  ) else $error("Measurement word not tracking its input");

  // Restore and fieldbus write to one slot in the same cycle
  chk_write_beats_load: assert property ( // [RULE13]
    user_wr_w && nv_load_valid && nv_load_slot == user_slot_w
    |=> user_reg[$past(user_slot_w)] == $past(req_wdata)
  ) else $error("Restore overrode a fieldbus write");

  cov_fault_clear: cover property (
    latched_monitor_flags != 32'h0000_0000 ##1 fault_reset
    ##1 latched_monitor_flags == 32'h0000_0000
  );

  cov_stop_capture: cover property (
    stop_take_w ##1 stop_error_code_reg != 16'h0000
  );

  cov_user_write_read: cover property (
    user_wr_w ##1 req_valid && !req_write && is_user_w
  );

  cov_ro_error: cover property (
    req_valid && req_write && is_ro_w ##1 resp_error
  );

  // Back-to-back requests keep resp_valid high
  cov_back_to_back: cover property (
    req_valid ##1 req_valid && resp_valid
  );

endmodule

// ===== bench/drmsb_master.sv
/*
  Fieldbus master model: issues one parameter access at a time.
  Assumes the bank answers exactly one cycle after each request.
*/
`timescale 1ns/1ps
module drmsb_master (
  // Clock
  input wire logic clk,
  // Request
  output logic req_valid,
  output logic req_write,
  output logic req_space,
  output logic [15:0] req_mb_addr,
  output logic [15:0] req_co_index,
  output logic [7:0] req_co_sub,
  output logic [31:0] req_wdata,
  // Answer
  input wire logic resp_valid,
  input wire logic resp_error,
  input wire logic [31:0] resp_rdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_space = 1'b0;
    req_mb_addr = 16'h0;
    {req_co_index, req_co_sub} = 24'h0;
    req_wdata = 32'h0;
  end

  // Key: Modbus address in bits 15:0, or CANopen index:sub
  task automatic access(input logic wr, input logic sp, input logic [23:0] key,
      input logic [31:0] wd, output logic [33:0] ans);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_space <= sp;
    req_mb_addr <= key[15:0];
    {req_co_index, req_co_sub} <= key;
    req_wdata <= wd;
    @(posedge clk);
    // Released data and Modbus address lines flip so stale values never pass for live ones
    req_valid <= 1'b0;
    req_wdata <= ~wd;
    req_mb_addr <= ~key[15:0];
    #1;
    ans = {resp_valid, resp_error, resp_rdata};
  endtask

  // Write then read one key on consecutive edges, valid held high throughout
  task automatic burst(input logic sp, input logic [23:0] key, input logic [31:0] wd,
      output logic [33:0] ans_wr, output logic [33:0] ans_rd);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_space <= sp;
    req_mb_addr <= key[15:0];
    {req_co_index, req_co_sub} <= key;
    req_wdata <= wd;
    @(posedge clk);
    req_write <= 1'b0;
    #1;
    ans_wr = {resp_valid, resp_error, resp_rdata};
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    ans_rd = {resp_valid, resp_error, resp_rdata};
  endtask
endmodule

// ===== bench/tb_top.sv
/*
  Self-checking bench of the drive monitor status bank.
  Assumes the master model in drmsb_master and the package drmsb_pkg.
*/
`timescale 1ns/1ps
module tb_top;
  import drmsb_pkg::*;
  // Bits 5, 11, 13 and 25 to 28 never carry a condition
  localparam logic [31:0] RSV = 32'h1e00_2820;
  localparam logic [31:0] LAT = ~RSV;
  typedef struct packed {
    logic wr;
    logic sp;
    logic [23:0] key;
    logic [31:0] wd;
    logic err;
    logic [31:0] rd;
  } drmsb_row_t;

  logic clk, rstn, req_valid, req_write, req_space, resp_valid, resp_error;
  logic [15:0] req_mb_addr, req_co_index, stop_code, dc_in, temp_in, exp_stop;
  logic [7:0] req_co_sub;
  logic [31:0] req_wdata, resp_rdata, live_conditions, nv_load_data, nv_save_data;
  logic fault_reset, stop_event, nv_load_valid, nv_save_valid;
  logic [2:0] stop_class;
  logic [1:0] nv_load_slot, nv_save_slot;
  logic [33:0] ans, ans_rd;
  int fails, samples_checked;

  drmsb_row_t rows [0:22] = '{
    '{1'b0, 1'b0, 24'h001c10, 32'h0, 1'b0, LAT},
    '{1'b0, 1'b1, 24'h301c08, 32'h0, 1'b0, LAT},
    '{1'b0, 1'b0, 24'h001c0e, 32'h0, 1'b0, LAT},
    '{1'b0, 1'b1, 24'h603f00, 32'h0, 1'b0, 32'h1234},
    '{1'b0, 1'b0, 24'h001c0a, 32'h0, 1'b0, 32'h1234},
    '{1'b0, 1'b0, 24'h001c1e, 32'h0, 1'b0, 32'h0fa3},
    '{1'b0, 1'b1, 24'h301c0f, 32'h0, 1'b0, 32'h0fa3},
    '{1'b0, 1'b1, 24'h301c10, 32'h0, 1'b0, 32'hffec},
    '{1'b0, 1'b0, 24'h001c20, 32'h0, 1'b0, 32'hffec},
    '{1'b1, 1'b0, 24'h00013e, 32'ha5a5_0001, 1'b0, 32'h0},
    '{1'b1, 1'b1, 24'h300120, 32'h5a5a_0002, 1'b0, 32'h0},
    '{1'b1, 1'b0, 24'h000142, 32'h0123_4567, 1'b0, 32'h0},
    '{1'b0, 1'b1, 24'h30011f, 32'h0, 1'b0, 32'ha5a5_0001},
    '{1'b0, 1'b0, 24'h000140, 32'h0, 1'b0, 32'h5a5a_0002},
    '{1'b0, 1'b1, 24'h300121, 32'h0, 1'b0, 32'h0123_4567},
    '{1'b1, 1'b0, 24'h001c0a, 32'hffff, 1'b1, 32'h0},
    '{1'b1, 1'b1, 24'h301c08, 32'hffff, 1'b1, 32'h0},
    '{1'b1, 1'b0, 24'h001c20, 32'h7, 1'b1, 32'h0},
    '{1'b1, 1'b1, 24'h301c0f, 32'h7, 1'b1, 32'h0},
    '{1'b1, 1'b0, 24'h001c0e, 32'h7, 1'b1, 32'h0},
    '{1'b0, 1'b0, 24'h00013f, 32'h0, 1'b1, 32'h0},
    '{1'b0, 1'b1, 24'h301c09, 32'h0, 1'b1, 32'h0},
    '{1'b0, 1'b0, 24'h001c0a, 32'h0, 1'b0, 32'h1234}
  };

  drmsb_bank u_drmsb_bank (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req_write(req_write), .req_space(req_space), .req_mb_addr(req_mb_addr),
    .req_co_index(req_co_index), .req_co_sub(req_co_sub), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_error(resp_error), .resp_rdata(resp_rdata),
    .live_conditions(live_conditions), .fault_reset(fault_reset),
    .stop_event(stop_event), .stop_class(stop_class), .stop_code(stop_code),
    .dc_bus_voltage_in(dc_in), .power_stage_temperature_in(temp_in),
    .nv_load_valid(nv_load_valid), .nv_load_slot(nv_load_slot),
    .nv_load_data(nv_load_data), .nv_save_valid(nv_save_valid),
    .nv_save_slot(nv_save_slot), .nv_save_data(nv_save_data));

  drmsb_master u_drmsb_master (.clk(clk), .req_valid(req_valid), .req_write(req_write),
    .req_space(req_space), .req_mb_addr(req_mb_addr), .req_co_index(req_co_index),
    .req_co_sub(req_co_sub), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_error(resp_error), .resp_rdata(resp_rdata));

  // ---------------------------------------------------------------
  // Clock, watchdog and helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run is well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    complete_run();
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic sp, input logic [23:0] key, input logic [31:0] exp);
    u_drmsb_master.access(1'b0, sp, key, 32'h0, ans);
    check(ans, {2'b10, exp});
  endtask

  task automatic pulse_clear();
    @(posedge clk);
    fault_reset <= 1'b1;
    @(posedge clk);
    fault_reset <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    {live_conditions, fault_reset, stop_event, stop_class, stop_code} = '0;
    {dc_in, temp_in, nv_load_valid, nv_load_slot, nv_load_data} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    check({32'h0, resp_valid, nv_save_valid}, 34'h0);
    rd_chk(1'b0, 24'h00013e, 32'h0);
    rd_chk(1'b1, 24'h603f00, 32'h0);
    rd_chk(1'b0, 24'h001c10, 32'h0);
    $display("test reset done");
    @(posedge clk);
    live_conditions <= 32'hffff_ffff;
    dc_in <= 16'h0fa3;
    temp_in <= 16'hffec;
    {stop_event, stop_class, stop_code} <= {1'b1, 3'h2, 16'h1234};
    @(posedge clk);
    stop_event <= 1'b0;
    foreach (rows[i]) begin
      u_drmsb_master.access(rows[i].wr, rows[i].sp, rows[i].key, rows[i].wd, ans);
      check(ans, {1'b1, rows[i].err, rows[i].rd});
    end
    $display("test table done");
    // Each bit alone, cleared and set on the same edge
    for (int b = 0; b < 32; b++) begin
      @(posedge clk);
      live_conditions <= 32'h1 << b;
      fault_reset <= 1'b1;
      @(posedge clk);
      fault_reset <= 1'b0;
      rd_chk(1'b0, 24'h001c10, (32'h1 << b) & LAT);
      rd_chk(1'b1, 24'h301c07, (32'h1 << b) & LAT);
    end
    @(posedge clk);
    live_conditions <= 32'h0;
    rd_chk(1'b0, 24'h001c10, 32'h8000_0000);
    rd_chk(1'b0, 24'h001c0e, 32'h0);
    pulse_clear();
    rd_chk(1'b1, 24'h301c08, 32'h0);
    $display("test flags done");
    exp_stop = 16'h1234;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      {stop_event, stop_class, stop_code} <= {1'b1, 3'(c), 16'h1000 + 16'(c)};
      @(posedge clk);
      stop_event <= 1'b0;
      if (c >= 1 && c <= 4) exp_stop = 16'h1000 + 16'(c);
      rd_chk(1'b0, 24'h001c0a, {16'h0, exp_stop});
    end
    pulse_clear();
    rd_chk(1'b1, 24'h603f00, 32'h1004);
    $display("test stop done");
    u_drmsb_master.access(1'b1, 1'b1, 24'h300121, 32'h600d_0003, ans);
    check(ans, {2'b10, 32'h0});
    check({nv_save_slot, nv_save_data}, {2'h2, 32'h600d_0003});
    check({33'h0, nv_save_valid}, 34'h1);
    @(posedge clk);
    {nv_load_valid, nv_load_slot, nv_load_data} <= {1'b1, 2'h0, 32'hfeed_0001};
    @(posedge clk);
    nv_load_valid <= 1'b0;
    rd_chk(1'b0, 24'h00013e, 32'hfeed_0001);
    $display("test store done");
    // Write and read back to back while a restore hits the same slot
    fork
      u_drmsb_master.burst(1'b0, 24'h000140, 32'hc0de_0002, ans, ans_rd);
      begin
        @(posedge clk);
        {nv_load_valid, nv_load_slot, nv_load_data} <= {1'b1, 2'h1, 32'hbad0_0001};
        @(posedge clk);
        nv_load_valid <= 1'b0;
      end
    join
    check(ans, {2'b10, 32'h0});
    check(ans_rd, {2'b10, 32'hc0de_0002});
    $display("test back to back done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(1'b0, 24'h000142, 32'h0);
    rd_chk(1'b0, 24'h001c0a, 32'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule
